// ---- logic/abbe_cfg.svh ----
// constants for the arithmetic, bit and branch execution datapath
`ifndef ABBE_CFG_SVH
`define ABBE_CFG_SVH
`define ABBE_DATA_W     8
`define ABBE_ADDR_W     7
`define ABBE_IP_W       15
`define ABBE_OFS_W      9
`define ABBE_MSB        7
`define ABBE_NIB_BIT    4
`define ABBE_DEST_ACC   1'h0
`define ABBE_DEST_REG   1'h1
`define ABBE_ZERO_BYTE  8'h00
`define ABBE_ACC_RST    8'h00
`define ABBE_IP_RST     15'h0000
`define ABBE_IP_STEP    15'h0001
`define ABBE_LSB        0
`define ABBE_BIT_ONE    8'h01
`define ABBE_ADDR_RST   7'h00
`define ABBE_FLAG_RST   1'h0
`endif

// ---- logic/abbe_pkg.sv ----
// types for the arithmetic, bit and branch execution datapath
package abbe_pkg;
	typedef enum logic [2:0] {
		OP_IDLE        = 3'h0,
		OP_ADD_REG     = 3'h1,
		OP_ADD_CARRY   = 3'h2,
		OP_SHIFT_RIGHT = 3'h3,
		OP_BIT_CLEAR   = 3'h4,
		OP_SKIP_ZERO   = 3'h5,
		OP_REL_JUMP    = 3'h6
	} abbe_op_type;

	typedef enum logic [0:0] {
		ST_RUN   = 1'h0,
		ST_FLUSH = 1'h1
	} abbe_state_type;

	typedef struct packed {
		abbe_state_type state;
		logic [7:0]     acc;
		logic           carry;
		logic           nibble_half_flag;
		logic           zero;
		logic [14:0]    instruction_pointer;
		logic           wr_en;
		logic [6:0]     wr_addr;
		logic [7:0]     wr_data;
		logic           flush;
	} abbe_regs_type;
endpackage

// ---- logic/abbe_exec.sv ----
// execution datapath for add, shift, bit clear, bit skip and relative jump
// Contract
// RQ1: add accumulator and register, address 0..127
// RQ2: destination bit zero accumulator, one register
// RQ3: add with carry updates carry, nibble, zero
// RQ4: shift right keeps msb, bit0 into carry
// RQ5: bit clear zeroes indexed bit, flags kept
// RQ6: skip-if-zero discards next when bit zero
// RQ7: jump loads pointer plus one plus offset
// RQ8: jump takes two cycles, flags unchanged
// RQ9: carry add and shift honour destination
// RQ10: pointer change or skip adds flush cycle
// RQ11: carry bit7, nibble bit3, zero on zero
`timescale 1ns/1ns
`include "abbe_cfg.svh"
module abbe_exec (
	input  wire logic        clk_in,         // instruction clock, 50 MHz
	input  wire logic        reset_n_in,     // synchronous reset, active low
	input  wire logic        clk_en_in,      // freezes all state while low
	input  wire logic        issue_in,       // instruction valid this cycle
	input  wire logic [2:0]  op_in,          // operation code, abbe_op_type
	input  wire logic [6:0]  reg_addr_in,    // data register address
	input  wire logic        dest_in,        // 0 accumulator, 1 register
	input  wire logic [2:0]  bit_sel_in,     // bit index 0..7
	input  wire logic [8:0]  offset_in,      // signed jump offset
	input  wire logic [7:0]  reg_data_in,    // register file read data
	output logic [7:0]       acc_out,        // accumulator
	output logic             carry_out,      // carry flag
	output logic             nibble_half_flag_out, // nibble carry flag
	output logic             zero_out,       // zero flag
	output logic [14:0]      instruction_pointer_out, // program counter
	output logic             wr_en_out,      // register write strobe
	output logic [6:0]       wr_addr_out,    // register write address
	output logic [7:0]       wr_data_out,    // register write data
	output logic             flush_out       // the previous cycle was a discarded slot
);
	abbe_pkg::abbe_regs_type r;
	abbe_pkg::abbe_regs_type next_r;
	abbe_pkg::abbe_op_type   op;
	logic [8:0]              sum9;
	logic [4:0]              nib5;
	logic [7:0]              result;
	logic                    is_add;
	logic                    writes;
	logic                    sel_bit;
	logic [14:0]             ofs_ext;

	assign op = abbe_pkg::abbe_op_type'(op_in);

	// shared adder; carry-in only for the carry form
	always_comb begin
		is_add = (op == abbe_pkg::OP_ADD_REG) || (op == abbe_pkg::OP_ADD_CARRY); // RQ1
		sum9 = {1'b0, r.acc} + {1'b0, reg_data_in}
			+ {8'h00, (op == abbe_pkg::OP_ADD_CARRY) & r.carry}; // RQ3
		nib5 = {1'b0, r.acc[`ABBE_NIB_BIT - 1:`ABBE_LSB]}
			+ {1'b0, reg_data_in[`ABBE_NIB_BIT - 1:`ABBE_LSB]}
			+ {4'h0, (op == abbe_pkg::OP_ADD_CARRY) & r.carry}; // RQ11
		sel_bit = reg_data_in[bit_sel_in];
		ofs_ext = {{(`ABBE_IP_W - `ABBE_OFS_W){offset_in[`ABBE_OFS_W - 1]}}, offset_in}; // RQ7
		if (op == abbe_pkg::OP_SHIFT_RIGHT) begin
			result = {reg_data_in[`ABBE_MSB], reg_data_in[`ABBE_MSB:`ABBE_LSB + 1]}; // RQ4
		end else if (op == abbe_pkg::OP_BIT_CLEAR) begin
			result = reg_data_in & ~(`ABBE_BIT_ONE << bit_sel_in); // RQ5
		end else begin
			result = sum9[`ABBE_MSB:`ABBE_LSB];
		end
		writes = is_add || (op == abbe_pkg::OP_SHIFT_RIGHT) || (op == abbe_pkg::OP_BIT_CLEAR);
	end

	// next-state: the fetched slot after a taken jump or skip is turned into a no-op
	always_comb begin
		next_r = r;
		next_r.wr_en = 1'b0;
		next_r.flush = 1'b0;
		case (r.state)
			abbe_pkg::ST_FLUSH: begin
				next_r.state = abbe_pkg::ST_RUN; // RQ10
				next_r.flush = 1'b1;
				next_r.instruction_pointer = r.instruction_pointer + `ABBE_IP_STEP;
			end
			default: begin
				if (issue_in) begin
					next_r.instruction_pointer = r.instruction_pointer + `ABBE_IP_STEP;
					if (writes) begin
						// bit clear always targets the register
						if (op == abbe_pkg::OP_BIT_CLEAR || dest_in == `ABBE_DEST_REG) begin
							next_r.wr_en   = 1'b1; // RQ2 RQ9
							next_r.wr_addr = reg_addr_in;
							next_r.wr_data = result;
						end else begin
							next_r.acc = result; // RQ2 RQ9
						end
					end
					if (is_add) begin
						next_r.carry = sum9[`ABBE_DATA_W]; // RQ11
						next_r.nibble_half_flag = nib5[`ABBE_NIB_BIT]; // RQ3
						next_r.zero = (sum9[`ABBE_MSB:`ABBE_LSB] == `ABBE_ZERO_BYTE); // RQ11
					end
					if (op == abbe_pkg::OP_SHIFT_RIGHT) begin
						next_r.carry = reg_data_in[`ABBE_LSB]; // RQ4
						next_r.zero = (result == `ABBE_ZERO_BYTE);
					end
					if (op == abbe_pkg::OP_SKIP_ZERO && !sel_bit) begin
						next_r.state = abbe_pkg::ST_FLUSH; // RQ6
					end
					if (op == abbe_pkg::OP_REL_JUMP) begin
						// flags untouched; fetched successor discarded
						next_r.instruction_pointer = r.instruction_pointer + `ABBE_IP_STEP
							+ ofs_ext; // RQ7
						next_r.state = abbe_pkg::ST_FLUSH; // RQ8
					end
				end
			end
		endcase
	end

	// single register for all state; enable freezes everything
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			r <= '{state: abbe_pkg::ST_RUN, acc: `ABBE_ACC_RST, carry: `ABBE_FLAG_RST,
				nibble_half_flag: `ABBE_FLAG_RST, zero: `ABBE_FLAG_RST,
				instruction_pointer: `ABBE_IP_RST, wr_en: `ABBE_FLAG_RST,
				wr_addr: `ABBE_ADDR_RST, wr_data: `ABBE_ZERO_BYTE, flush: `ABBE_FLAG_RST};
		end else if (clk_en_in) begin
			r <= next_r;
		end
	end

	assign acc_out                 = r.acc;
	assign carry_out               = r.carry;
	assign nibble_half_flag_out    = r.nibble_half_flag;
	assign zero_out                = r.zero;
	assign instruction_pointer_out = r.instruction_pointer;
	assign wr_en_out               = r.wr_en;
	assign wr_addr_out             = r.wr_addr;
	assign wr_data_out             = r.wr_data;
	assign flush_out               = r.flush;

	// jump then flush slot: two cycles; each sequence names the issue step of a behaviour
	sequence seq_jump_issued;
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_REL_JUMP;
	endsequence

	sequence seq_skip_taken;
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_SKIP_ZERO
		&& !sel_bit;
	endsequence

	sequence seq_skip_passed;
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_SKIP_ZERO
		&& sel_bit;
	endsequence

	chk_jump_two_cycles: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ8
		seq_jump_issued ##1 clk_en_in |=> flush_out)
		else $error("jump not followed by flush slot");

	chk_jump_flags_kept: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ8
		seq_jump_issued |=> $stable({carry_out, zero_out, nibble_half_flag_out}))
		else $error("jump altered flags");

	chk_jump_target: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ7
		seq_jump_issued |=> instruction_pointer_out == $past(r.instruction_pointer)
		+ `ABBE_IP_STEP + $past(ofs_ext))
		else $error("jump target wrong");

	chk_skip_flush: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ6
		seq_skip_taken ##1 clk_en_in |=> flush_out)
		else $error("skip did not flush");

	chk_skip_no_flush: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ6
		seq_skip_passed |=> r.state == abbe_pkg::ST_RUN)
		else $error("skip flushed on set bit");

	// the slot after a passed skip must execute, not be thrown away
	chk_skip_set_slot: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ6
		seq_skip_passed ##1 clk_en_in |=> !flush_out)
		else $error("skip discarded a slot on set bit");

	// the discarded slot only steps the pointer, whatever the fetch presents
	chk_flush_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ10
		r.state == abbe_pkg::ST_FLUSH && clk_en_in |=> flush_out && !wr_en_out
		&& $stable({acc_out, carry_out, nibble_half_flag_out, zero_out})
		&& instruction_pointer_out == $past(instruction_pointer_out) + `ABBE_IP_STEP)
		else $error("flush slot not idle");

	chk_add_carry_out: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ11
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && is_add
		|=> carry_out == $past(sum9[`ABBE_DATA_W])
		&& zero_out == ($past(sum9[`ABBE_MSB:`ABBE_LSB]) == `ABBE_ZERO_BYTE))
		else $error("add flags wrong");

	// carry into bit 4 recovered from the sum bit, independent of the nibble adder
	chk_add_nibble: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ3
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && is_add
		|=> nibble_half_flag_out == $past(sum9[`ABBE_NIB_BIT] ^ r.acc[`ABBE_NIB_BIT]
		^ reg_data_in[`ABBE_NIB_BIT]))
		else $error("add nibble flag wrong");

	chk_add_dest_acc: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ2
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && is_add && !dest_in
		|=> acc_out == $past(sum9[`ABBE_MSB:`ABBE_LSB]) && !wr_en_out)
		else $error("add to accumulator wrong");

	chk_add_dest_reg: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ2
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && is_add && dest_in
		|=> wr_en_out && wr_addr_out == $past(reg_addr_in) && $stable(acc_out)
		&& wr_data_out == $past(r.acc + reg_data_in + (r.carry && op == abbe_pkg::OP_ADD_CARRY)))
		else $error("add to register wrong");

	chk_shift_carry: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ4
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_SHIFT_RIGHT
		|=> carry_out == $past(reg_data_in[`ABBE_LSB]))
		else $error("shift carry wrong");

	// the result lands in whichever destination was selected
	chk_shift_result: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ4
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_SHIFT_RIGHT
		|=> ($past(dest_in) ? wr_data_out : acc_out) == {$past(reg_data_in[`ABBE_MSB]),
		$past(reg_data_in[`ABBE_MSB:`ABBE_LSB + 1])})
		else $error("shift result wrong");

	chk_shift_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ4
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_SHIFT_RIGHT
		|=> zero_out == ($past(reg_data_in[`ABBE_MSB:`ABBE_LSB + 1]) == '0))
		else $error("shift zero flag wrong");

	chk_clear_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ5
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_BIT_CLEAR
		|=> wr_en_out && !wr_data_out[$past(bit_sel_in)] && $stable(carry_out))
		else $error("bit clear wrong");

	chk_clear_flags_kept: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ5
		issue_in && clk_en_in && r.state == abbe_pkg::ST_RUN && op == abbe_pkg::OP_BIT_CLEAR
		|=> $stable({acc_out, carry_out, nibble_half_flag_out, zero_out}))
		else $error("bit clear altered flags");
endmodule

// ---- testbench/tb_arith_bit_branch_exec.sv ----
// self-checking bench for the arithmetic, bit and branch execution datapath
`timescale 1ns/1ns
module tb_arith_bit_branch_exec;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        clk_en_in = 1'b1;
	logic        issue_in = 1'b0;
	logic [2:0]  op_in = 3'h0;
	logic [6:0]  reg_addr_in = 7'h00;
	logic        dest_in = 1'b0;
	logic [2:0]  bit_sel_in = 3'h0;
	logic [8:0]  offset_in = 9'h000;
	logic [7:0]  reg_data_in = 8'h00;
	logic [7:0]  acc_out;
	logic        carry_out, nibble_half_flag_out, zero_out, wr_en_out, flush_out;
	logic [14:0] instruction_pointer_out, ptr_seen;
	logic [6:0]  wr_addr_out;
	logic [7:0]  wr_data_out;
	logic [8:0]  k;
	int          err_total = 0;
	int          total_checks = 0;

	abbe_exec dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
		.issue_in(issue_in), .op_in(op_in), .reg_addr_in(reg_addr_in), .dest_in(dest_in),
		.bit_sel_in(bit_sel_in), .offset_in(offset_in), .reg_data_in(reg_data_in),
		.acc_out(acc_out), .carry_out(carry_out), .nibble_half_flag_out(nibble_half_flag_out),
		.zero_out(zero_out), .instruction_pointer_out(instruction_pointer_out),
		.wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
		.flush_out(flush_out));

	// 50 MHz clock
	initial begin
		forever #10 clk_in = ~clk_in;
	end

	// case inequality so an unknown never passes
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one issued slot: drive at the falling edge, results settle by the next one
	task automatic run(input logic [2:0] op, input logic [6:0] a, input logic d,
		input logic [2:0] b, input logic [8:0] ofs, input logic [7:0] v);
		issue_in = 1'b1;
		op_in = op;
		reg_addr_in = a;
		dest_in = d;
		bit_sel_in = b;
		offset_in = ofs;
		reg_data_in = v;
		@(negedge clk_in);
	endtask

	task automatic flags(input logic [2:0] e);
		check("flags", {13'h0000, carry_out, nibble_half_flag_out, zero_out}, {13'h0000, e});
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		check("write", {wr_en_out, wr_addr_out, wr_data_out}, {1'b1, a, v});
	endtask

	// watchdog: the sequence needs well under a hundred cycles
	initial begin
		#20000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		run(3'h1, 7'h00, 1'b0, 3'h0, 9'h000, 8'h3C);
		check("acc", acc_out, 8'h3C);
		flags(3'b000);
		run(3'h1, 7'h7F, 1'b0, 3'h0, 9'h000, 8'hC4);
		check("acc", acc_out, 8'h00);
		flags(3'b111);
		run(3'h2, 7'h7F, 1'b1, 3'h0, 9'h000, 8'h0F);
		wr(7'h7F, 8'h10);
		check("acc", acc_out, 8'h00);
		flags(3'b010);
		run(3'h2, 7'h00, 1'b0, 3'h0, 9'h000, 8'hFF);
		check("acc", acc_out, 8'hFF);
		flags(3'b000);
		run(3'h3, 7'h05, 1'b0, 3'h0, 9'h000, 8'h81);
		check("acc", acc_out, 8'hC0);
		flags(3'b100);
		run(3'h3, 7'h05, 1'b1, 3'h0, 9'h000, 8'h01);
		wr(7'h05, 8'h00);
		check("acc", acc_out, 8'hC0);
		flags(3'b101);
		// every bit index, flags must survive untouched
		for (int b = 0; b < 8; b++) begin
			run(3'h4, 7'h12, 1'b0, b[2:0], 9'h000, 8'hFF);
			wr(7'h12, 8'hFF & ~(8'h01 << b));
			flags(3'b101);
		end
		run(3'h5, 7'h03, 1'b0, 3'h1, 9'h000, 8'h02);
		run(3'h1, 7'h00, 1'b0, 3'h0, 9'h000, 8'h40);
		check("flush", flush_out, 1'b0);
		check("acc", acc_out, 8'h00);
		flags(3'b101);
		run(3'h5, 7'h03, 1'b0, 3'h1, 9'h000, 8'hFD);
		run(3'h1, 7'h00, 1'b0, 3'h0, 9'h000, 8'h01);
		check("flush", flush_out, 1'b1);
		check("acc", acc_out, 8'h00);
		// both ends of the offset range, each followed by a discarded add
		for (int j = 0; j < 2; j++) begin
			k = j == 0 ? 9'h100 : 9'h0FF;
			ptr_seen = instruction_pointer_out + 15'h0001;
			run(3'h6, 7'h00, 1'b0, 3'h0, k, 8'h00);
			check("pointer", instruction_pointer_out, 15'(ptr_seen + {{6{k[8]}}, k}));
			run(3'h1, 7'h00, 1'b0, 3'h0, 9'h000, 8'h01);
			check("flush", flush_out, 1'b1);
			check("acc", acc_out, 8'h00);
			flags(3'b101);
		end
		wrap_up();
	end
endmodule
